// File: rtl/ldc_pkg.sv
// Notes on behaviour
// - bit 7 picks high or low current reference
// - duty code 0..99 gives 1..100 percent on-time
// - duty codes above 99 keep sinks off
// - dimming register defaults: code 30 (31 percent), low range
// - lockout reloads all eight bits; all read/write
// - two-bit field picks 100/200/500/1000 Hz
// - sink-enable low disables sinks and boost stage
// - one waveform drives both sinks, 200 Hz default
package ldc_pkg;

  // register map, byte offsets on the parallel register port
  localparam logic [7:0] LDC_ADDR_SETUP = 8'h18;
  localparam logic [7:0] LDC_ADDR_DIM = 8'h19;

  // reset values
  localparam logic [7:0] LDC_SETUP_RST = 8'h10;
  localparam logic [7:0] LDC_DIM_RST = 8'h1E;

  // field positions
  localparam int LDC_RANGE_BIT = 7;
  localparam int LDC_DUTY_MSB = 6;
  localparam int LDC_SINK_ON_BIT = 7;
  localparam int LDC_FREQ_MSB = 5;
  localparam int LDC_FREQ_LSB = 4;
  localparam logic [7:0] LDC_SETUP_RW_MASK = 8'hB0;

  // duty coding
  localparam int LDC_DUTY_W = 7;
  localparam logic [6:0] LDC_DUTY_MAX = 7'h63;
  localparam int LDC_STEPS = 100;
  localparam logic [6:0] LDC_LAST_STEP = 7'h63;

  // timing
  localparam int LDC_CLK_HZ = 100_000_000;
  localparam int LDC_F0_HZ = 100;
  localparam int LDC_F1_HZ = 200;
  localparam int LDC_F2_HZ = 500;
  localparam int LDC_F3_HZ = 1000;
  localparam int LDC_STEP_W = 20;

  typedef enum logic [1:0] {
    LDC_FREQ_100 = 2'h0,
    LDC_FREQ_200 = 2'h1,
    LDC_FREQ_500 = 2'h2,
    LDC_FREQ_1000 = 2'h3
  } ldc_freq_e;

  // dimming register content
  typedef struct packed {
    logic range_hi;
    logic [6:0] duty;
  } ldc_dim_s;

  // setup register content
  typedef struct packed {
    logic sink_on;
    ldc_freq_e freq;
  } ldc_setup_s;

endpackage

// File: rtl/ldc_pwm_timer.sv
`timescale 1ns/100ps
module ldc_pwm_timer
  import ldc_pkg::*;
(
  input wire logic clk_sys_i, // system clock
  input wire logic resetn_i, // async reset, low
  input wire logic ce_i, // clock enable
  input wire logic run_i, // timer runs while high
  input wire logic [LDC_STEP_W-1:0] step_cyc_i, // cycles per 1% step
  output logic [6:0] step_o, // current step 0..99
  output logic period_start_o // high while next edge wraps to 0
);

  logic [LDC_STEP_W-1:0] cnt_q;
  logic [LDC_STEP_W-1:0] cnt_d;
  logic [6:0] step_q;
  logic [6:0] step_d;
  logic start_d;

  // one period is one hundred equal steps
  always_comb begin
    cnt_d = cnt_q;
    step_d = step_q;
    start_d = 1'b0;
    if (!run_i) begin
      cnt_d = '0;
      step_d = '0;
    end else if (cnt_q >= step_cyc_i - LDC_STEP_W'(1)) begin
      cnt_d = '0;
      if (step_q == LDC_LAST_STEP) begin
        step_d = '0;
        start_d = 1'b1;
      end else begin
        step_d = step_q + 7'h01;
      end
    end else begin
      cnt_d = cnt_q + LDC_STEP_W'(1);
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      cnt_q <= '0;
      step_q <= '0;
    end else if (ce_i) begin
      cnt_q <= cnt_d;
      step_q <= step_d;
    end
  end

  // left unregistered so new settings land on the very edge that
  // restarts step 0; a registered pulse would arrive one cycle late
  assign step_o = step_q;
  assign period_start_o = start_d;

endmodule

// File: rtl/ldc_top.sv
`timescale 1ns/100ps
module ldc_top
  import ldc_pkg::*;
#(
  // cycles per 1% step at each frequency; shorten for simulation
  parameter int unsigned STEP_CYC_F0 = LDC_CLK_HZ / (LDC_F0_HZ * LDC_STEPS),
  parameter int unsigned STEP_CYC_F1 = LDC_CLK_HZ / (LDC_F1_HZ * LDC_STEPS),
  parameter int unsigned STEP_CYC_F2 = LDC_CLK_HZ / (LDC_F2_HZ * LDC_STEPS),
  parameter int unsigned STEP_CYC_F3 = LDC_CLK_HZ / (LDC_F3_HZ * LDC_STEPS)
)
(
  input wire logic clk_sys_i, // system clock, 100 MHz
  input wire logic resetn_i, // async reset, low
  input wire logic ce_i, // clock enable, freezes all
  input wire logic undervoltage_lockout_i, // lockout level, async
  input wire logic [7:0] reg_addr_i, // register offset
  input wire logic [7:0] reg_wdata_i, // write data
  input wire logic reg_wr_i, // write strobe
  input wire logic reg_rd_i, // read strobe
  output logic [7:0] reg_rdata_o, // read data, held
  output logic reg_rvalid_o, // read data valid pulse
  output logic string_a_sink_o, // sink a on
  output logic string_b_sink_o, // sink b on
  output logic high_range_sel_o, // 1: high range reference
  output logic boost_enable_o // led boost stage on
);

  // lockout arrives from the analogue side
  logic undervoltage_lockout_meta_q;
  logic undervoltage_lockout_sync_q;

  // software-visible registers
  ldc_dim_s dim_q;
  ldc_dim_s dim_d;
  ldc_setup_s setup_q;
  ldc_setup_s setup_d;

  // copies used by the modulator
  ldc_dim_s act_dim_q;
  ldc_dim_s act_dim_d;
  ldc_freq_e act_freq_q;
  ldc_freq_e act_freq_d;

  // read port
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;

  // pin drivers
  logic sink_q;
  logic sink_d;
  logic range_q;
  logic range_d;
  logic boost_q;
  logic boost_d;

  // timer link
  logic [6:0] step;
  logic period_start;
  logic [LDC_STEP_W-1:0] step_cyc;
  logic duty_ok;

  // two flops before anything looks at the lockout level
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      undervoltage_lockout_meta_q <= 1'b0;
      undervoltage_lockout_sync_q <= 1'b0;
    end else if (ce_i) begin
      undervoltage_lockout_meta_q <= undervoltage_lockout_i;
      undervoltage_lockout_sync_q <= undervoltage_lockout_meta_q;
    end
  end

  // register writes; lockout reload has priority over software
  always_comb begin
    dim_d = dim_q;
    setup_d = setup_q;
    if (undervoltage_lockout_sync_q) begin
      dim_d = ldc_dim_s'(LDC_DIM_RST);
      setup_d = ldc_setup_s'({LDC_SETUP_RST[LDC_SINK_ON_BIT],
                              LDC_SETUP_RST[LDC_FREQ_MSB:LDC_FREQ_LSB]});
    end else if (reg_wr_i) begin
      if (reg_addr_i == LDC_ADDR_DIM) begin
        dim_d = ldc_dim_s'(reg_wdata_i);
      end else if (reg_addr_i == LDC_ADDR_SETUP) begin
        setup_d.sink_on = reg_wdata_i[LDC_SINK_ON_BIT];
        setup_d.freq =
          ldc_freq_e'(reg_wdata_i[LDC_FREQ_MSB:LDC_FREQ_LSB]);
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      dim_q <= ldc_dim_s'(LDC_DIM_RST);
      setup_q <= ldc_setup_s'({LDC_SETUP_RST[LDC_SINK_ON_BIT],
                               LDC_SETUP_RST[LDC_FREQ_MSB:LDC_FREQ_LSB]});
    end else if (ce_i) begin
      dim_q <= dim_d;
      setup_q <= setup_d;
    end
  end

  // read mux; unmapped offsets and reserved bits read zero
  always_comb begin
    rdata_d = rdata_q;
    rvalid_d = 1'b0;
    if (reg_rd_i) begin
      rvalid_d = 1'b1;
      unique case (reg_addr_i)
        LDC_ADDR_DIM: begin
          rdata_d = dim_q;
        end
        LDC_ADDR_SETUP: begin
          rdata_d = {setup_q.sink_on, 1'b0, setup_q.freq, 4'h0}
                    & LDC_SETUP_RW_MASK;
        end
        default: begin
          rdata_d = 8'h00;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else if (ce_i) begin
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  // settings are taken over only on the wrap edge, or freely while
  // sink enable is low, so no runt pulse reaches the strings; the
  // next values are used so an enabling write also sets the rate
  always_comb begin
    act_dim_d = act_dim_q;
    act_freq_d = act_freq_q;
    if (period_start || !setup_q.sink_on) begin
      act_dim_d = dim_d;
      act_freq_d = setup_d.freq;
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      act_dim_q <= ldc_dim_s'(LDC_DIM_RST);
      act_freq_q <= ldc_freq_e'(LDC_SETUP_RST[LDC_FREQ_MSB:LDC_FREQ_LSB]);
    end else if (ce_i) begin
      act_dim_q <= act_dim_d;
      act_freq_q <= act_freq_d;
    end
  end

  // step length per selected frequency
  always_comb begin
    unique case (act_freq_q)
      LDC_FREQ_100: step_cyc = LDC_STEP_W'(STEP_CYC_F0);
      LDC_FREQ_200: step_cyc = LDC_STEP_W'(STEP_CYC_F1);
      LDC_FREQ_500: step_cyc = LDC_STEP_W'(STEP_CYC_F2);
      LDC_FREQ_1000: step_cyc = LDC_STEP_W'(STEP_CYC_F3);
    endcase
  end

  ldc_pwm_timer u_timer (
    .clk_sys_i(clk_sys_i),
    .resetn_i(resetn_i),
    .ce_i(ce_i),
    .run_i(setup_q.sink_on),
    .step_cyc_i(step_cyc),
    .step_o(step),
    .period_start_o(period_start)
  );

  // code n keeps the sinks on for steps 0..n, i.e. n+1 percent
  assign duty_ok = (act_dim_q.duty <= LDC_DUTY_MAX);

  // sink, range and boost drivers
  always_comb begin
    sink_d = 1'b0;
    if (setup_q.sink_on && duty_ok) begin
      sink_d = (step <= act_dim_q.duty);
    end
    range_d = act_dim_q.range_hi;
    boost_d = setup_q.sink_on;
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sink_q <= 1'b0;
      range_q <= 1'b0;
      boost_q <= 1'b0;
    end else if (ce_i) begin
      sink_q <= sink_d;
      range_q <= range_d;
      boost_q <= boost_d;
    end
  end

  // one flop feeds both sinks so the strings switch together
  assign string_a_sink_o = sink_q;
  assign string_b_sink_o = sink_q;
  assign high_range_sel_o = range_q;
  assign boost_enable_o = boost_q;
  assign reg_rdata_o = rdata_q;
  assign reg_rvalid_o = rvalid_q;

endmodule

// File: verif/ldc_assertions.sv
`timescale 1ns/100ps
module ldc_checker
  import ldc_pkg::*;
(
  input wire logic clk_sys_i, // clock
  input wire logic resetn_i, // reset, low
  input wire logic ce_i, // enable
  input wire logic undervoltage_lockout_i, // lockout
  input wire logic [7:0] reg_addr_i, // offset
  input wire logic [7:0] reg_wdata_i, // data
  input wire logic reg_wr_i, // write
  input wire logic reg_rd_i, // read
  input wire logic [7:0] reg_rdata_o, // rdata
  input wire logic reg_rvalid_o, // rvalid
  input wire logic string_a_sink_o, // sink a
  input wire logic string_b_sink_o, // sink b
  input wire logic boost_enable_o // boost
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  sequence s_rd(logic [7:0] a);
    ce_i && reg_rd_i && reg_addr_i == a;
  endsequence
  // lockout long enough to pass the two-flop sync and reload
  sequence s_held;
    undervoltage_lockout_i [*6];
  endsequence
  chk_sinks_tied: assert property (string_a_sink_o == string_b_sink_o)
    else $error("sinks differ");
  chk_read_answer: assert property (ce_i && reg_rd_i |=> reg_rvalid_o)
    else $error("no read answer");
  chk_rdata_hold: assert property (!$past(ce_i && reg_rd_i) |-> $stable(reg_rdata_o))
    else $error("rdata moved");
  chk_unmapped_zero: assert property (ce_i && reg_rd_i && reg_addr_i[7:1] != 7'h0c |=> reg_rdata_o == 8'h00)
    else $error("unmapped read not zero");
  chk_sink_enable: assert property (!boost_enable_o |-> !string_a_sink_o)
    else $error("sink on while disabled");
  chk_write_boost: assert property (!undervoltage_lockout_i [*3] ##0 (ce_i && reg_wr_i && reg_addr_i == LDC_ADDR_SETUP) |-> ##2 boost_enable_o == $past(reg_wdata_i[7], 2))
    else $error("boost does not follow enable");
  chk_lockout_off: assert property (s_held |-> !boost_enable_o && !string_a_sink_o)
    else $error("drive on in lockout");
  chk_lockout_dim: assert property (s_held ##0 s_rd(LDC_ADDR_DIM) |=> reg_rdata_o == LDC_DIM_RST)
    else $error("dimming default lost");
endmodule

// File: verif/ldc_led_string.sv
`timescale 1ns/100ps
module ldc_led_string (
  input wire logic clk_sys_i, // clock
  input wire logic sink_a_i, // string a drive
  input wire logic sink_b_i, // string b drive
  output logic [15:0] on_cnt_o, // cycles lit
  output logic [15:0] last_len_o // last pulse length
);
  logic [15:0] cnt_q = 16'h0000;
  logic [15:0] run_q = 16'h0000;
  logic [15:0] len_q = 16'h0000;
  assign on_cnt_o = cnt_q;
  assign last_len_o = len_q;
  // strings light only while both sinks draw current
  always @(posedge clk_sys_i) begin
    if (sink_a_i && sink_b_i) begin
      cnt_q <= cnt_q + 16'h0001;
      run_q <= run_q + 16'h0001;
    end else begin
      if (run_q != 16'h0000) len_q <= run_q;
      run_q <= 16'h0000;
    end
  end
endmodule

// File: verif/tb_top.sv
`timescale 1ns/100ps
module tb_top;
  import ldc_pkg::*;
  logic clk_sys_i = 1'b0, resetn_i = 1'b0, ce_i = 1'b1;
  logic undervoltage_lockout_i = 1'b0, reg_wr_i = 1'b0, reg_rd_i = 1'b0;
  logic [7:0] reg_addr_i = 8'h00, reg_wdata_i = 8'h00, reg_rdata_o;
  logic reg_rvalid_o, string_a_sink_o, string_b_sink_o;
  logic high_range_sel_o, boost_enable_o;
  logic [15:0] on_cnt, last_len;
  int error_cnt = 0, checks_done = 0;
  integer seed = 32'hda915dac;
  ldc_top #(.STEP_CYC_F0(4), .STEP_CYC_F1(3), .STEP_CYC_F2(2),
    .STEP_CYC_F3(1)) dut_u (.clk_sys_i, .resetn_i, .ce_i,
    .undervoltage_lockout_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i,
    .reg_rd_i, .reg_rdata_o, .reg_rvalid_o, .string_a_sink_o,
    .string_b_sink_o, .high_range_sel_o, .boost_enable_o);
  ldc_led_string led_u (.clk_sys_i(clk_sys_i), .sink_a_i(string_a_sink_o),
    .sink_b_i(string_b_sink_o), .on_cnt_o(on_cnt), .last_len_o(last_len));
  initial forever #5 clk_sys_i = ~clk_sys_i;
  task automatic chk(input logic [15:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("checks_done=%0d error_cnt=%0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge clk_sys_i) #1;
    reg_addr_i = a;
    reg_wdata_i = d;
    reg_wr_i = 1'b1;
    @(posedge clk_sys_i) #1;
    reg_wr_i = 1'b0;
  endtask
  // rdata is registered at the taking edge and then held
  task automatic rd(input logic [7:0] a, exp);
    @(posedge clk_sys_i) #1;
    reg_addr_i = a;
    reg_rd_i = 1'b1;
    @(posedge clk_sys_i) #1;
    reg_rd_i = 1'b0;
    chk(reg_rvalid_o, 1'b1);
    chk(reg_rdata_o, exp);
  endtask
  // lit cycles over any whole period equal the on-time
  task automatic win(input int cyc, output logic [15:0] n);
    logic [15:0] s;
    s = on_cnt;
    repeat (cyc) @(posedge clk_sys_i);
    #1 n = on_cnt - s;
  endtask
  function automatic logic [15:0] exp_on(logic [6:0] n, int f);
    return n > LDC_DUTY_MAX ? 16'h0000 : 16'((n + 1) * (4 - f));
  endfunction
  task automatic edge_wait(input logic lvl);
    for (int i = 0; i < 900 && string_a_sink_o !== lvl; i++)
      @(posedge clk_sys_i) #1;
    chk(string_a_sink_o, lvl);
    @(posedge clk_sys_i) #1;
  endtask
  initial begin
    logic [15:0] x;
    logic [6:0] code;
    logic r;
    repeat (16) @(posedge clk_sys_i);
    #1 resetn_i = 1'b1;
    rd(LDC_ADDR_DIM, LDC_DIM_RST);
    rd(LDC_ADDR_SETUP, LDC_SETUP_RST);
    rd(8'h1a, 8'h00);
    wr(LDC_ADDR_SETUP, 8'h90);
    win(300, x);
    win(300, x);
    chk(x, 16'h005d);
    for (int f = 0; f < 4; f++) for (int k = 0; k < 4; k++) begin
      code = k == 0 ? 7'h00 : k == 1 ? 7'h63 : 7'($unsigned($random(seed)) % 100);
      if (k == 3) code = 7'h64 + 7'($unsigned($random(seed)) % 28);
      r = 1'($random(seed));
      wr(LDC_ADDR_SETUP, 8'h00);
      @(posedge clk_sys_i) #1;
      chk(boost_enable_o, 1'b0);
      chk(string_a_sink_o, 1'b0);
      wr(LDC_ADDR_DIM, {r, code});
      wr(LDC_ADDR_SETUP, {2'b10, 2'(f), 4'h0});
      win(100 * (4 - f), x);
      win(100 * (4 - f), x);
      chk(x, exp_on(code, f));
      chk(high_range_sel_o, r);
    end
    wr(LDC_ADDR_DIM, 8'h28);
    wr(LDC_ADDR_SETUP, 8'h80);
    edge_wait(1'b0);
    edge_wait(1'b1);
    wr(LDC_ADDR_DIM, 8'h8a);
    edge_wait(1'b0);
    chk(last_len, 16'h00a4);
    chk(high_range_sel_o, 1'b0);
    edge_wait(1'b1);
    edge_wait(1'b0);
    chk(last_len, 16'h002c);
    // off code must not leave a one-cycle pulse at the wrap
    wr(LDC_ADDR_DIM, 8'h7f);
    win(400, x);
    chk(x, 16'h0000);
    chk(high_range_sel_o, 1'b0);
    // and the first on step after an off period keeps full length
    wr(LDC_ADDR_DIM, 8'h00);
    edge_wait(1'b1);
    edge_wait(1'b0);
    chk(last_len, 16'h0004);
    wr(LDC_ADDR_DIM, 8'ha5);
    rd(LDC_ADDR_DIM, 8'ha5);
    undervoltage_lockout_i = 1'b1;
    repeat (8) @(posedge clk_sys_i);
    wr(LDC_ADDR_DIM, 8'h55);
    rd(LDC_ADDR_DIM, LDC_DIM_RST);
    rd(LDC_ADDR_SETUP, LDC_SETUP_RST);
    undervoltage_lockout_i = 1'b0;
    repeat (4) @(posedge clk_sys_i);
    rd(LDC_ADDR_DIM, LDC_DIM_RST);
    // a write while the clock enable is low must not land
    ce_i = 1'b0;
    wr(LDC_ADDR_DIM, 8'h33);
    ce_i = 1'b1;
    rd(LDC_ADDR_DIM, LDC_DIM_RST);
    results;
  end
  initial begin
    repeat (60000) @(posedge clk_sys_i);
    error_cnt++;
    results;
  end
endmodule
bind ldc_top ldc_checker chk_u (.clk_sys_i, .resetn_i, .ce_i,
  .undervoltage_lockout_i, .reg_addr_i, .reg_wdata_i, .reg_wr_i, .reg_rd_i,
  .reg_rdata_o, .reg_rvalid_o, .string_a_sink_o, .string_b_sink_o,
  .boost_enable_o);
